// ===== hw/flash_ctrl_defines.vh
// Command codes, status bits and timing for the flash status and power controller
`ifndef FLASH_CTRL_DEFINES_VH
`define FLASH_CTRL_DEFINES_VH
`define CLK_MHZ 50
`define CMD_READ_ARRAY 8'hFF
`define CMD_READ_STATUS 8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_ERASE_SETUP 8'h20
`define CMD_ERASE_CONFIRM 8'hD0
`define CMD_PROG_SETUP 8'h40
`define SR_DONE 7
`define SR_ERASE_ERR 5
`define SR_PROG_ERR 4
`define SR_SUPPLY_ERR 3
`define T_WP_NS 50
`define T_WPH_NS 20
`define T_RP_NS 150
`define T_RS_NS 1000
`define T_ACE_NS 90
`define T_OD_NS 25
`define T_WB_NS 200
// Least times round up to whole cycles
`define NS_TO_CYC(ns) (((ns) * `CLK_MHZ + 999) / 1000)
`define OP_PROGRAM 2'h0
`define OP_ERASE 2'h1
`define OP_CLEAR 2'h2
`define OP_READ_ARRAY 2'h3
`endif

// ===== hw/flash_status_power_control.v
// Host controller driving program, erase, status check and power pins of a parallel flash
`include "flash_ctrl_defines.vh"
module flash_status_power_control #(
  parameter ADDR_W = 20,
  parameter DATA_W = 8,
  parameter POLL_LIMIT = 32'd25000000
) (
  input wire i_sys_clk,
  input wire i_rst_n,
  input wire i_clk_en,
  input wire i_supply_ok,
  input wire i_powerdown,
  input wire i_req,
  input wire [1:0] i_op,
  input wire [ADDR_W-1:0] i_addr,
  input wire [DATA_W-1:0] i_wdata,
  input wire [DATA_W-1:0] i_dq_in,
  output reg o_ready,
  output reg o_done,
  output reg [7:0] o_status,
  output reg o_locked,
  output reg o_timeout,
  output reg o_reset_powerdown_pin,
  output reg o_ce_n,
  output reg o_we_n,
  output reg o_oe_n,
  output reg [ADDR_W-1:0] o_addr,
  output reg [DATA_W-1:0] o_dq_out,
  output reg o_dq_oe
);
  localparam integer C_WP_I = `NS_TO_CYC(`T_WP_NS);
  localparam integer C_WPH_I = `NS_TO_CYC(`T_WPH_NS);
  localparam integer C_RP_I = `NS_TO_CYC(`T_RP_NS);
  localparam integer C_RS_I = `NS_TO_CYC(`T_RS_NS);
  // One spare cycle so status has settled before it is sampled
  localparam integer C_ACE_I = `NS_TO_CYC(`T_ACE_NS) + 1;
  localparam integer C_OD_I = `NS_TO_CYC(`T_OD_NS);
  localparam integer C_WB_I = `NS_TO_CYC(`T_WB_NS);
  localparam [7:0] C_WP = C_WP_I[7:0];
  localparam [7:0] C_WPH = C_WPH_I[7:0];
  localparam [7:0] C_RP = C_RP_I[7:0];
  localparam [7:0] C_RS = C_RS_I[7:0];
  localparam [7:0] C_ACE = C_ACE_I[7:0];
  localparam [7:0] C_OD = C_OD_I[7:0];
  localparam [7:0] C_WB = C_WB_I[7:0];

  localparam [3:0] S_PWRUP = 4'h0;
  localparam [3:0] S_RELEASE = 4'h1;
  localparam [3:0] S_IDLE = 4'h2;
  localparam [3:0] S_WLOW = 4'h3;
  localparam [3:0] S_WHIGH = 4'h4;
  localparam [3:0] S_WAITB = 4'h5;
  localparam [3:0] S_RLOW = 4'h6;
  localparam [3:0] S_RHIGH = 4'h7;
  localparam [3:0] S_PDOWN = 4'h8;

  reg [3:0] state;
  reg [7:0] cnt;
  reg [1:0] op;
  reg [1:0] phase;
  reg [7:0] cmd;
  reg [31:0] poll;

  function [7:0] cmd_of;
    input [1:0] f_op;
    input [1:0] f_phase;
    begin
      case (f_op)
        `OP_PROGRAM: cmd_of = (f_phase == 2'h0) ? `CMD_PROG_SETUP : 8'h00;
        `OP_ERASE: cmd_of = (f_phase == 2'h0) ? `CMD_ERASE_SETUP : `CMD_ERASE_CONFIRM;
        `OP_CLEAR: cmd_of = `CMD_CLEAR_STATUS;
        default: cmd_of = `CMD_READ_ARRAY;
      endcase
    end
  endfunction

  // Single-cycle ops skip the second write
  function last_phase;
    input [1:0] f_op;
    input [1:0] f_phase;
    begin
      last_phase = (f_op == `OP_CLEAR) || (f_op == `OP_READ_ARRAY) || (f_phase == 2'h1);
    end
  endfunction

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state <= S_PWRUP;
      cnt <= 8'h00;
      op <= 2'h0;
      phase <= 2'h0;
      cmd <= 8'h00;
      poll <= 32'h0;
      o_ready <= 1'b0;
      o_done <= 1'b0;
      o_status <= 8'h00;
      o_locked <= 1'b0;
      o_timeout <= 1'b0;
      o_reset_powerdown_pin <= 1'b0;
      o_ce_n <= 1'b1;
      o_we_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_addr <= {ADDR_W{1'b0}};
      o_dq_out <= {DATA_W{1'b0}};
      o_dq_oe <= 1'b0;
    end else if (i_clk_en) begin
      o_done <= 1'b0;
      case (state)
        S_PWRUP: begin
          // Pin stays low until the supply is valid and minimum low time passes
          o_reset_powerdown_pin <= 1'b0;
          o_ce_n <= 1'b1;
          o_we_n <= 1'b1;
          if (!i_supply_ok) begin
            cnt <= 8'h00;
          end else if (cnt >= C_RP) begin
            o_reset_powerdown_pin <= 1'b1;
            cnt <= 8'h00;
            state <= S_RELEASE;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        S_RELEASE: begin
          // Device wakes in array read with cleared status
          if (cnt >= C_RS) begin
            o_status <= 8'h00;
            o_locked <= 1'b0;
            o_ready <= 1'b1;
            state <= S_IDLE;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        S_IDLE: begin
          o_ce_n <= 1'b1;
          o_dq_oe <= 1'b0;
          if (!i_supply_ok) begin
            o_ready <= 1'b0;
            cnt <= 8'h00;
            state <= S_PWRUP;
          end else if (i_powerdown) begin
            o_reset_powerdown_pin <= 1'b0;
            o_ready <= 1'b0;
            state <= S_PDOWN;
          end else if (i_req) begin
            o_ready <= 1'b0;
            o_timeout <= 1'b0;
            op <= i_op;
            phase <= 2'h0;
            if (o_locked && (i_op == `OP_PROGRAM || i_op == `OP_ERASE)) begin
              o_done <= 1'b1;
              o_ready <= 1'b1;
            end else begin
              o_addr <= i_addr;
              cmd <= cmd_of(i_op, 2'h0);
              o_dq_out <= cmd_of(i_op, 2'h0);
              o_dq_oe <= 1'b1;
              o_ce_n <= 1'b0;
              o_we_n <= 1'b0;
              cnt <= 8'h00;
              state <= S_WLOW;
            end
          end
        end
        S_WLOW: begin
          if (cnt >= C_WP) begin
            o_we_n <= 1'b1;
            cnt <= 8'h00;
            state <= S_WHIGH;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        S_WHIGH: begin
          if (cnt >= C_WPH) begin
            cnt <= 8'h00;
            if (!last_phase(op, phase)) begin
              phase <= 2'h1;
              o_dq_out <= (op == `OP_PROGRAM) ? i_wdata : cmd_of(op, 2'h1);
              o_we_n <= 1'b0;
              state <= S_WLOW;
            end else if (op == `OP_PROGRAM || op == `OP_ERASE) begin
              // Release CE; the sequencer keeps running on its own
              o_ce_n <= 1'b1;
              o_dq_oe <= 1'b0;
              poll <= 32'h0;
              state <= S_WAITB;
            end else begin
              if (op == `OP_CLEAR) begin
                o_status <= 8'h00;
                o_locked <= 1'b0;
              end
              o_ce_n <= 1'b1;
              o_dq_oe <= 1'b0;
              o_done <= 1'b1;
              o_ready <= 1'b1;
              state <= S_IDLE;
            end
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        S_WAITB: begin
          if (cnt >= C_WB) begin
            cnt <= 8'h00;
            o_ce_n <= 1'b0;
            o_oe_n <= 1'b0;
            state <= S_RLOW;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        S_RLOW: begin
          // Reads return status while busy
          if (cnt >= C_ACE) begin
            o_oe_n <= 1'b1;
            o_ce_n <= 1'b1;
            cnt <= 8'h00;
            poll <= poll + 32'h1;
            if (i_dq_in[`SR_DONE]) begin
              o_status <= i_dq_in[7:0];
              o_locked <= i_dq_in[`SR_SUPPLY_ERR];
              op <= `OP_READ_ARRAY;
              phase <= 2'h0;
              state <= S_RHIGH;
            end else if (poll >= POLL_LIMIT) begin
              o_timeout <= 1'b1;
              o_status <= i_dq_in[7:0];
              op <= `OP_READ_ARRAY;
              state <= S_RHIGH;
            end else begin
              state <= S_WAITB;
            end
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        S_RHIGH: begin
          // Return to array read with one write of the read-array code
          if (cnt >= C_OD) begin
            cnt <= 8'h00;
            o_dq_out <= `CMD_READ_ARRAY;
            o_dq_oe <= 1'b1;
            o_ce_n <= 1'b0;
            o_we_n <= 1'b0;
            state <= S_WLOW;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        S_PDOWN: begin
          if (!i_powerdown) begin
            o_reset_powerdown_pin <= 1'b1;
            cnt <= 8'h00;
            state <= S_RELEASE;
          end
        end
        default: begin
          state <= S_PWRUP;
        end
      endcase
      // Supply loss drops the pin on the next enabled cycle, so no half-done write runs on
      if (!i_supply_ok && state != S_PWRUP) begin
        o_reset_powerdown_pin <= 1'b0;
        o_ready <= 1'b0;
        o_done <= 1'b0;
        o_ce_n <= 1'b1;
        o_we_n <= 1'b1;
        o_oe_n <= 1'b1;
        o_dq_oe <= 1'b0;
        cnt <= 8'h00;
        state <= S_PWRUP;
      end
    end
  end
endmodule // flash_status_power_control

// ===== tb/flash_dev_model.sv
// Behavioural flash device on the far side of the controller
module flash_dev_model #(parameter int BUSY_NS = 400) (
  input wire i_pin,
  input wire i_ce_n,
  input wire i_we_n,
  input wire i_oe_n,
  input wire [7:0] i_dq,
  input wire i_vpp_bad,
  input wire i_hang,
  output wire [7:0] o_dq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sr = 8'h80;
  logic [7:0] last = 8'h00;
  logic [1:0] pend = 2'h0;
  logic mode = 1'b0;
  logic busy = 1'b0;
  logic kind = 1'b0;
  wire drv = i_pin && !i_ce_n && !i_oe_n;
  wire [7:0] rd = (mode || busy) ? sr : 8'hA5;
  // Released bus shows inverse of last value, never a stale match
  assign o_dq = drv ? rd : ~last;
  always @* if (drv) last = rd;
  always @(negedge i_pin) begin
    sr = 8'h80;
    mode = 1'b0;
    pend = 2'h0;
  end
  always @(posedge i_we_n) if (i_pin && !i_ce_n && !busy) begin
    mode = 1'b1;
    // Second cycle is program data of any value; an erase second cycle other than D0 sets both error bits
    if (pend != 2'h0) begin
      kind = pend[1];
      if (pend == 2'h2 && i_dq != 8'hD0) sr[5:4] = 2'b11;
      else if (sr[3]) sr[4 + kind] = 1'b1;
      else busy = 1'b1;
      pend = 2'h0;
    end else case (i_dq)
      8'hFF: mode = 1'b0;
      8'h50: sr[5:3] = 3'b000;
      8'h40: pend = 2'h1;
      8'h20: pend = 2'h2;
      default: ;
    endcase
  end
  // Runs to the end whatever chip select does
  always @(posedge busy) begin
    sr[7] = 1'b0;
    #(BUSY_NS);
    // Hang keeps the sequencer busy past the poll limit
    wait (!i_hang);
    if (i_vpp_bad) sr[3] = 1'b1;
    if (i_vpp_bad) sr[4 + kind] = 1'b1;
    sr[7] = 1'b1;
    busy = 1'b0;
  end
endmodule // flash_dev_model

// ===== tb/flash_ctrl_chk.sv
// Assertions on the controller's flash side and its host done/ready handshake
`include "flash_ctrl_defines.vh"
module flash_ctrl_chk #(parameter DATA_W = 8) (
  input wire i_sys_clk,
  input wire i_rst_n,
  input wire i_supply_ok,
  input wire i_powerdown,
  input wire i_req,
  input wire [1:0] i_op,
  input wire o_ready,
  input wire o_done,
  input wire o_locked,
  input wire o_reset_powerdown_pin,
  input wire o_we_n,
  input wire o_oe_n,
  input wire [DATA_W-1:0] o_dq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  reg polled;
  reg [DATA_W-1:0] last_cmd;
  always @(posedge i_sys_clk) begin
    polled <= (!i_rst_n || o_done) ? 1'b0 : (polled || !o_oe_n);
    last_cmd <= !i_rst_n ? {DATA_W{1'b0}} : (!o_we_n ? o_dq_out : last_cmd);
  end
  sequence s_wr_start;
    $fell(o_we_n);
  endsequence
  sequence s_lock_req;
    o_ready && o_locked && i_req && !i_op[1] && i_supply_ok && !i_powerdown;
  endsequence
  property p_pin_low;
    !i_supply_ok ##1 !i_supply_ok |=> !o_reset_powerdown_pin;
  endproperty
  property p_clr_single;
    s_wr_start ##0 (o_dq_out == `CMD_CLEAR_STATUS) ##0 $past(o_ready) |=> !$fell(o_we_n) throughout (##[0:10] o_done);
  endproperty
  property p_ret_array;
    o_done && polled |-> last_cmd == `CMD_READ_ARRAY;
  endproperty
  property p_lockout;
    s_lock_req |=> o_we_n throughout (##[0:1] o_done);
  endproperty
  property p_again;
    o_done |-> o_ready;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin high without supply");
  a_clr_single: assert property (p_clr_single) else $error("clear not single");
  a_ret_array: assert property (p_ret_array) else $error("no read array");
  a_lockout: assert property (p_lockout) else $error("locked op issued");
  a_again: assert property (p_again) else $error("not ready at done");
endmodule // flash_ctrl_chk
bind flash_status_power_control flash_ctrl_chk #(.DATA_W(DATA_W)) chk_u (.i_sys_clk, .i_rst_n, .i_supply_ok,
  .i_powerdown, .i_req, .i_op, .o_ready, .o_done, .o_locked, .o_reset_powerdown_pin, .o_we_n, .o_oe_n, .o_dq_out);

// ===== tb/tb_flash_status_power_control.sv
// Testbench for the flash status and power controller
module tb_flash_status_power_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk = 0, i_rst_n = 0, i_supply_ok = 0, i_powerdown = 0, i_req = 0, vpp_bad = 0;
  logic clk_en = 1, hang = 0;
  logic [1:0] i_op = 2'h0;
  logic [19:0] i_addr = 20'h00000;
  logic [7:0] i_wdata = 8'h00;
  wire [7:0] dq_in, o_status, o_dq_out;
  wire [19:0] o_addr;
  wire o_ready, o_done, o_locked, o_timeout, pin, ce_n, we_n, oe_n, dq_oe;
  int err_count = 0, checks_done = 0, cyc = 0;
  flash_status_power_control #(.POLL_LIMIT(32'd50)) dut_u (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_clk_en(clk_en), .i_supply_ok(i_supply_ok), .i_powerdown(i_powerdown), .i_req(i_req), .i_op(i_op),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_dq_in(dq_in), .o_ready(o_ready), .o_done(o_done),
    .o_status(o_status), .o_locked(o_locked), .o_timeout(o_timeout), .o_reset_powerdown_pin(pin),
    .o_ce_n(ce_n), .o_we_n(we_n), .o_oe_n(oe_n), .o_addr(o_addr), .o_dq_out(o_dq_out), .o_dq_oe(dq_oe));
  flash_dev_model m_u (.i_pin(pin), .i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n), .i_dq(o_dq_out),
    .i_vpp_bad(vpp_bad), .i_hang(hang), .o_dq(dq_in));
  initial forever #10 i_sys_clk = ~i_sys_clk;
  // Generous ceiling; a full run with one poll timeout needs under two thousand cycles
  always @(posedge i_sys_clk) if (++cyc == 20000) begin
    err_count++;
    results();
  end
  task results;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task op(input [1:0] c, input [7:0] e);
    @(negedge i_sys_clk);
    while (o_ready !== 1'b1) @(negedge i_sys_clk);
    i_op = c;
    i_req = 1'b1;
    i_addr++;
    i_wdata += 8'h11;
    @(negedge i_sys_clk) i_req = 1'b0;
    while (o_done !== 1'b1) @(negedge i_sys_clk);
    chk(o_status, e);
    chk({ce_n, dq_oe}, 8'h02);
  endtask
  task t_freeze;
    int n[2];
    for (int k = 0; k < 2; k++) begin
      @(negedge i_sys_clk);
      while (o_ready !== 1'b1) @(negedge i_sys_clk);
      i_op = 2'h2;
      i_req = 1'b1;
      @(negedge i_sys_clk) i_req = 1'b0;
      n[k] = 1;
      if (k == 1) begin
        clk_en = 1'b0;
        repeat (3) @(negedge i_sys_clk);
        chk({ce_n, we_n, o_ready}, 8'h00);
        clk_en = 1'b1;
        n[k] = 4;
      end
      while (o_done !== 1'b1) begin
        @(negedge i_sys_clk);
        n[k]++;
      end
    end
    chk(n[1] - n[0], 8'h03);
  endtask
  task t_hang;
    hang = 1'b1;
    op(2'h0, 8'h00);
    chk(o_timeout, 8'h01);
    hang = 1'b0;
    op(2'h0, 8'h80);
    chk(o_timeout, 8'h00);
  endtask
  task t_power;
    repeat (20) @(negedge i_sys_clk);
    chk(pin, 8'h00);
    i_supply_ok = 1'b1;
    op(2'h3, 8'h00);
    chk(m_u.sr, 8'h80);
  endtask
  task t_prog;
    op(2'h0, 8'h80);
    op(2'h1, 8'h80);
    chk(o_addr[7:0], i_addr[7:0]);
    chk(m_u.mode, 8'h00);
  endtask
  task t_lock;
    vpp_bad = 1'b1;
    op(2'h1, 8'hA8);
    vpp_bad = 1'b0;
    chk(o_locked, 8'h01);
    op(2'h0, 8'hA8);
    chk(m_u.sr, 8'hA8);
    op(2'h2, 8'h00);
    chk(m_u.sr, 8'h80);
    op(2'h0, 8'h80);
  endtask
  task t_pd;
    i_powerdown = 1'b1;
    repeat (3) @(negedge i_sys_clk);
    chk(pin, 8'h00);
    i_powerdown = 1'b0;
    op(2'h0, 8'h80);
    i_supply_ok = 1'b0;
    repeat (3) @(negedge i_sys_clk);
    chk(pin, 8'h00);
    i_supply_ok = 1'b1;
    op(2'h3, 8'h00);
  endtask
  initial begin
    repeat (5) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    t_power;
    t_freeze;
    t_prog;
    t_lock;
    t_hang;
    t_pd;
    results();
  end
endmodule // tb_flash_status_power_control
